// File: verification/limit_switch_monitor.sv
// assertion checker for the limit switch output unit
`timescale 1ns/1ps
module limit_switch_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ready,
  input wire logic [limit_switch_pkg::POINTS-1:0] point_used,
  input wire logic [limit_switch_pkg::POINTS-1:0] point_src_word,
  input wire logic fetch_req,
  input wire logic fetch_is_axis,
  input wire logic [limit_switch_pkg::AXIS_W-1:0] fetch_axis,
  input wire logic [limit_switch_pkg::QTY_W-1:0] fetch_qty,
  input wire logic [limit_switch_pkg::SPACE_W-1:0] fetch_space,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::QTY_W-1:0] point_qty,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::AXIS_W-1:0] point_axis,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::SPACE_W-1:0] point_watch_space,
  input wire logic [limit_switch_pkg::OUT_BITS-1:0] limit_out,
  input wire logic sweep_busy
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  always_comb next_cnt = (rst_n && sweep_busy) ? cnt + 8'h01 : 8'h00;
  always_ff @(posedge mclk) cnt <= next_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_ready_clear: assert property (!ready |=> limit_out == 32'h0) else $error("outputs not cleared");
  chk_ready_start: assert property ($rose(ready) && !sweep_busy |=> sweep_busy) else $error("no sweep");
  chk_start_cause: assert property ($rose(sweep_busy) |-> $past(ready)) else $error("sweep not ready");
  chk_idle_fetch: assert property (!sweep_busy |-> !fetch_req) else $error("fetch while idle");
  chk_first_fetch: assert property ($rose(sweep_busy) |-> fetch_req == point_used[0]) else $error("first fetch");
  chk_fetch_kind: assert property ($rose(sweep_busy) && point_used[0] |-> fetch_is_axis == !point_src_word[0])
    else $error("fetch kind");
  chk_axis_select: assert property ($rose(sweep_busy) && point_used[0] && !point_src_word[0] |->
    fetch_qty == point_qty[3:0] && fetch_axis == point_axis[4:0]) else $error("axis select");
  chk_word_space: assert property ($rose(sweep_busy) && point_used[0] && point_src_word[0] |->
    fetch_space == point_watch_space[1:0]) else $error("word space");
  chk_sweep_len: assert property ($fell(sweep_busy) && $past(ready) |-> cnt == 8'h60) else $error("length");
  chk_out_commit: assert property (ready && $past(ready) && $changed(limit_out) |-> $fell(sweep_busy))
    else $error("output moved mid-sweep");
endmodule // limit_switch_monitor
bind limit_switch_output_compare limit_switch_monitor mon_u (.mclk, .rst_n, .ready, .point_used, .point_src_word,
  .fetch_req, .fetch_is_axis, .fetch_axis, .fetch_qty, .fetch_space, .point_qty, .point_axis, .point_watch_space,
  .limit_out, .sweep_busy);

// File: verification/limit_switch_output_compare_tb.sv
// testbench for the limit switch output unit
`timescale 1ns/1ps
module limit_switch_output_compare_tb;
  import limit_switch_pkg::*;
  logic mclk, rst_n, ready, model_large, fetch_req, fetch_is_axis, sweep_busy;
  logic [POINTS-1:0] point_used, point_src_word, point_on_const, point_off_const;
  logic [POINTS-1:0] enable_assigned, enable_bit, force_assigned, force_bit;
  logic [POINTS*QTY_W-1:0] point_qty;
  logic [POINTS*AXIS_W-1:0] point_axis;
  logic [POINTS*TGT_W-1:0] point_target;
  logic [POINTS*TYPE_W-1:0] point_word_type;
  logic [POINTS*SPACE_W-1:0] point_watch_space, point_on_space, point_off_space;
  logic [POINTS*IDX_W-1:0] point_watch_index, point_on_index, point_off_index;
  logic [POINTS*DATA_W-1:0] point_on_value, point_off_value;
  logic [AXIS_W-1:0] fetch_axis;
  logic [IDX_W-1:0] fetch_index;
  logic [DATA_W-1:0] fetch_data;
  logic [OUT_BITS-1:0] limit_out;
  int error_cnt, checks_done;
  limit_switch_output_compare #(.op_cycle_clocks(200)) dut_u (.mclk, .rst_n, .ready, .model_large, .point_used,
    .point_src_word, .point_qty, .point_axis, .point_word_type, .point_watch_space, .point_watch_index,
    .point_on_const, .point_on_value, .point_on_space, .point_on_index, .point_off_const, .point_off_value,
    .point_off_space, .point_off_index, .enable_assigned, .enable_bit, .force_assigned, .force_bit, .point_target,
    .fetch_req, .fetch_is_axis, .fetch_axis, .fetch_qty(), .fetch_space(), .fetch_index, .fetch_data, .limit_out,
    .sweep_busy);
  limit_switch_partner pu (.mclk, .fetch_req, .fetch_is_axis, .fetch_axis, .fetch_index, .fetch_data);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_busy(input logic lvl);
    int n = 0;
    while (sweep_busy !== lvl && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n == 400) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic sweep();
    wait_busy(1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  task automatic clr();
    {point_used, point_src_word, point_on_const, point_off_const, point_qty, point_axis, point_target} = '0;
    {enable_assigned, enable_bit, force_assigned, force_bit, point_word_type, point_watch_space} = '0;
    {point_watch_index, point_on_value, point_on_space, point_on_index, point_off_value} = '0;
    {point_off_space, point_off_index} = '0;
  endtask
  task automatic setp(input int p, input logic [3:0] q, input logic [4:0] ax, input logic [63:0] on_v, off_v,
                      input logic [4:0] t);
    point_used[p] = 1'b1;
    point_qty[p*4+:4] = q;
    point_axis[p*5+:5] = ax;
    point_on_const[p] = 1'b1;
    point_off_const[p] = 1'b1;
    point_on_value[p*64+:64] = on_v;
    point_off_value[p*64+:64] = off_v;
    point_target[p*5+:5] = t;
  endtask
  task automatic t_window();
    clr();
    pu.ax_val[3] = 32'h00000064;
    pu.ax_val[31] = 32'h1234FFF0;
    setp(0, QTY_REAL, 5'h03, 64'h64, 64'h96, 5'h00);
    setp(1, QTY_FEED, 5'h03, 64'h96, 64'h64, 5'h01);
    setp(2, QTY_REAL, 5'h03, 64'h64, 64'h64, 5'h02);
    setp(3, QTY_MOTOR_CURRENT, 5'h1F, 64'hFFFFFFFFFFFFFFEC, 64'h0, 5'h03);
    setp(4, QTY_MOTOR_SPEED, 5'h1F, 64'hFFFFFFFFFFFFFFF0, 64'h0, 5'h04);
    setp(31, QTY_DEVIATION, 5'h03, 64'h96, 64'h78, 5'h1F);
    sweep();
    check("window", limit_out, 32'h80000019);
  endtask
  task automatic t_gate();
    enable_assigned[0] = 1'b1;
    force_assigned[1] = 1'b1;
    force_bit[1] = 1'b1;
    force_assigned[3] = 1'b1;
    sweep();
    check("gate", limit_out, 32'h8000001A);
    enable_bit[0] = 1'b1;
    force_bit[1] = 1'b0;
    sweep();
    check("enable", limit_out, 32'h80000019);
    enable_bit[0] = 1'b0;
    point_target[24:20] = 5'h00;
    sweep();
    check("or", limit_out, 32'h80000009);
  endtask
  task automatic t_word();
    clr();
    {pu.wm[9], pu.wm[8], pu.wm[17], pu.wm[16]} = 64'hFFFFFF00FFFFFED4;
    {pu.wm[23], pu.wm[22], pu.wm[21], pu.wm[20]} = 64'h3FF8000000000000;
    {pu.wm[25], pu.wm[24]} = 32'h7FFF8000;
    setp(0, 4'h0, 5'h00, 64'h0, 64'h0, 5'h00);
    setp(1, 4'h0, 5'h00, 64'h3FF0000000000000, 64'h4000000000000000, 5'h01);
    setp(2, 4'h0, 5'h00, 64'hFFFFFFFFFFFF8000, 64'h5, 5'h02);
    point_src_word[2:0] = 3'h7;
    point_word_type[5:0] = {TYPE_INT16, TYPE_FLOAT64, TYPE_INT32};
    point_watch_space[1:0] = 2'h1;
    point_watch_index[38:0] = {13'h0018, 13'h0014, 13'h0008};
    point_on_const[0] = 1'b0;
    point_on_space[1:0] = 2'h2;
    point_on_index[12:0] = 13'h0010;
    sweep();
    check("word", limit_out, 32'h00000007);
    pu.wm[16] = 16'hFF38;
    sweep();
    check("refetch", limit_out, 32'h00000006);
  endtask
  task automatic t_model();
    clr();
    pu.ax_val[11] = 32'h0000000A;
    pu.ax_val[7] = 32'h0000000A;
    for (int q = 0; q < 10; q++) setp(q, q[3:0], 5'h0B, 64'h0, 64'h14, q[4:0]);
    sweep();
    check("large", limit_out, 32'h000003FF);
    model_large = 1'b0;
    for (int q = 0; q < 10; q++) point_axis[q*5+:5] = 5'h07;
    sweep();
    check("small", limit_out, 32'h0000001F);
  endtask
  task automatic t_ready();
    ready = 1'b0;
    repeat (2) @(negedge mclk);
    check("drop", limit_out, 32'h0);
    ready = 1'b1;
    sweep();
    check("rise", limit_out, 32'h0000001F);
  endtask
  initial begin
    clr();
    {rst_n, ready, model_large} = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    ready = 1'b1;
    model_large = 1'b1;
    t_window();
    t_gate();
    t_word();
    t_model();
    t_ready();
    test_done();
  end
endmodule // limit_switch_output_compare_tb

// File: verification/limit_switch_partner.sv
// far-side model: axis data producers and word memory
`timescale 1ns/1ps
module limit_switch_partner (
  input wire logic mclk,
  input wire logic fetch_req,
  input wire logic fetch_is_axis,
  input wire logic [limit_switch_pkg::AXIS_W-1:0] fetch_axis,
  input wire logic [limit_switch_pkg::IDX_W-1:0] fetch_index,
  output logic [limit_switch_pkg::DATA_W-1:0] fetch_data
);
  import limit_switch_pkg::*;
  logic [31:0] ax_val [32];
  logic [15:0] wm [64];
  logic [DATA_W-1:0] last;
  logic [5:0] i;
  initial foreach (wm[k]) wm[k] = 16'hA5C3;
  initial foreach (ax_val[k]) ax_val[k] = 32'h5A3C0F96;
  assign i = fetch_index[5:0];
  always_comb begin
    if (!fetch_req) fetch_data = ~last;
    else if (fetch_is_axis) fetch_data = {~ax_val[fetch_axis], ax_val[fetch_axis]};
    else fetch_data = {wm[i+6'h3], wm[i+6'h2], wm[i+6'h1], wm[i]};
  end
  always_ff @(posedge mclk) last <= fetch_data;
endmodule // limit_switch_partner

// File: verilog/limit_switch_output_compare.sv
// limit switch output unit: per-point window compare swept once per operation cycle
//
// Summary of operation
// R1: each point drives output from window compare
// R2: watch source is axis quantity or word
// R3: position 32-bit, current/speed 16-bit, axes 1-32/1-8
// R4: virtual/encoder 32-bit, axes 1-12 large only
// R5: configurer sets word type, even index
// R6: thresholds word or constant, watch type
// R7: no enable bit means always enabled
// R8: enable bit low forces result low; the code lets a high force bit still drive the result high
// R9: force bit high drives output high
// R10: no/low force: enable and window decide
// R11: signed compare, window shape by threshold order
// R12: results on same output bit are ORed
// R13: evaluate only while ready; thresholds refetched
// R14: up to 32 points, any axis count
// R15: outputs registered, updated together per cycle
`timescale 1ns/1ps
module limit_switch_output_compare #(
  parameter int op_cycle_clocks = limit_switch_pkg::OP_CYCLE_CLOCKS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ready,
  input wire logic model_large,
  input wire logic [limit_switch_pkg::POINTS-1:0] point_used,
  input wire logic [limit_switch_pkg::POINTS-1:0] point_src_word,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::QTY_W-1:0] point_qty,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::AXIS_W-1:0] point_axis,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::TYPE_W-1:0] point_word_type,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::SPACE_W-1:0] point_watch_space,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::IDX_W-1:0] point_watch_index,
  input wire logic [limit_switch_pkg::POINTS-1:0] point_on_const,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::DATA_W-1:0] point_on_value,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::SPACE_W-1:0] point_on_space,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::IDX_W-1:0] point_on_index,
  input wire logic [limit_switch_pkg::POINTS-1:0] point_off_const,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::DATA_W-1:0] point_off_value,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::SPACE_W-1:0] point_off_space,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::IDX_W-1:0] point_off_index,
  input wire logic [limit_switch_pkg::POINTS-1:0] enable_assigned,
  input wire logic [limit_switch_pkg::POINTS-1:0] enable_bit,
  input wire logic [limit_switch_pkg::POINTS-1:0] force_assigned,
  input wire logic [limit_switch_pkg::POINTS-1:0] force_bit,
  input wire logic [limit_switch_pkg::POINTS*limit_switch_pkg::TGT_W-1:0] point_target,
  output logic fetch_req,
  output logic fetch_is_axis,
  output logic [limit_switch_pkg::AXIS_W-1:0] fetch_axis,
  output logic [limit_switch_pkg::QTY_W-1:0] fetch_qty,
  output logic [limit_switch_pkg::SPACE_W-1:0] fetch_space,
  output logic [limit_switch_pkg::IDX_W-1:0] fetch_index,
  input wire logic [limit_switch_pkg::DATA_W-1:0] fetch_data,
  output logic [limit_switch_pkg::OUT_BITS-1:0] limit_out,
  output logic sweep_busy
);
  import limit_switch_pkg::*;

  localparam logic [31:0] TICK_LAST = 32'(op_cycle_clocks - 1);

  seq_state_t state, next_state;
  logic [PT_W-1:0] point, next_point;
  logic [OUT_BITS-1:0] acc, next_acc;
  logic [OUT_BITS-1:0] next_limit_out;
  logic [DATA_W-1:0] watch_key, next_watch_key;
  logic [DATA_W-1:0] on_key, next_on_key;
  logic watch_ok, next_watch_ok;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic op_tick;
  logic ready_q;
  logic ready_rise;

  logic [QTY_W-1:0] p_qty;
  logic [AXIS_W-1:0] p_axis;
  logic [TYPE_W-1:0] p_type;
  logic [DATA_W-1:0] off_key;
  logic [DATA_W-1:0] axis_raw;
  logic in_window;
  logic axis_ok;
  logic enabled;
  logic forced;
  logic result;
  logic [OUT_BITS-1:0] result_bit;

  // operation cycle divider
  always_comb begin
    op_tick = (tick_cnt == TICK_LAST);
    next_tick_cnt = op_tick ? 32'h0 : tick_cnt + 32'h1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      ready_q <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      ready_q <= ready;
    end
  end

  assign ready_rise = ready && !ready_q;

  // current point's configuration
  always_comb begin
    p_qty = point_qty[point*QTY_W +: QTY_W];
    p_axis = point_axis[point*AXIS_W +: AXIS_W];
    if (point_src_word[point]) begin
      p_type = point_word_type[point*TYPE_W +: TYPE_W]; // [R2] [R5]
    end else if (p_qty == QTY_MOTOR_CURRENT || p_qty == QTY_MOTOR_SPEED) begin
      p_type = TYPE_INT16; // [R3]
    end else begin
      p_type = TYPE_INT32; // [R3] [R4]
    end
    if (point_src_word[point]) begin
      axis_ok = 1'b1;
    end else if (p_qty <= QTY_MOTOR_SPEED) begin
      axis_ok = {1'b0, p_axis} < (model_large ? AXES_LARGE : AXES_SMALL); // [R3]
    end else if (p_qty <= QTY_ENCODER) begin
      axis_ok = model_large && ({1'b0, p_axis} < VIRT_AXES_LARGE); // [R4]
    end else begin
      axis_ok = 1'b0;
    end
    axis_raw = {{32{fetch_data[31]}}, fetch_data[31:0]};
    off_key = order_key(point_off_const[point] ? point_off_value[point*DATA_W +: DATA_W] : fetch_data, p_type); // [R6]
    enabled = !enable_assigned[point] || enable_bit[point]; // [R7] [R8]
    forced = force_assigned[point] && force_bit[point]; // [R9] [R10]
    result = point_used[point] && (forced || (enabled && watch_ok && in_window)); // [R1] [R9] [R10]
    result_bit = '0;
    result_bit[point_target[point*TGT_W +: TGT_W]] = result;
  end

  limit_window u_window (
    .watch_key(watch_key),
    .on_key(on_key),
    .off_key(off_key),
    .in_window(in_window)
  );

  // fetch requests for the stage in progress
  always_comb begin
    fetch_req = 1'b0;
    fetch_is_axis = 1'b0;
    fetch_axis = p_axis;
    fetch_qty = p_qty;
    fetch_space = point_watch_space[point*SPACE_W +: SPACE_W];
    fetch_index = point_watch_index[point*IDX_W +: IDX_W];
    unique case (state)
      ST_IDLE: begin
      end
      ST_WATCH: begin
        fetch_req = point_used[point];
        fetch_is_axis = !point_src_word[point]; // [R2]
      end
      ST_ON: begin
        fetch_req = point_used[point] && !point_on_const[point]; // [R13]
        fetch_space = point_on_space[point*SPACE_W +: SPACE_W];
        fetch_index = point_on_index[point*IDX_W +: IDX_W];
      end
      ST_OFF: begin
        fetch_req = point_used[point] && !point_off_const[point]; // [R13]
        fetch_space = point_off_space[point*SPACE_W +: SPACE_W];
        fetch_index = point_off_index[point*IDX_W +: IDX_W];
      end
    endcase
  end

  // sweep sequencer
  always_comb begin
    next_state = state;
    next_point = point;
    next_acc = acc;
    next_limit_out = limit_out;
    next_watch_key = watch_key;
    next_watch_ok = watch_ok;
    next_on_key = on_key;
    unique case (state)
      ST_IDLE: begin
        if (ready_rise || op_tick) begin
          next_state = ST_WATCH; // [R13]
          next_point = '0; // [R14]
          next_acc = '0;
        end
      end
      ST_WATCH: begin
        next_watch_key = order_key(point_src_word[point] ? fetch_data : axis_raw, p_type); // [R2] [R3]
        next_watch_ok = axis_ok;
        next_state = ST_ON;
      end
      ST_ON: begin
        next_on_key = order_key(point_on_const[point] ? point_on_value[point*DATA_W +: DATA_W] : fetch_data,
                                p_type); // [R6]
        next_state = ST_OFF;
      end
      ST_OFF: begin
        next_acc = acc | result_bit; // [R12]
        if (point == LAST_POINT) begin
          next_limit_out = acc | result_bit; // [R15]
          next_state = ST_IDLE;
        end else begin
          next_point = point + 5'h01; // [R14]
          next_state = ST_WATCH;
        end
      end
    endcase
    if (!ready) begin
      next_state = ST_IDLE;
      next_limit_out = '0; // [R13]
      next_acc = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      point <= '0;
      acc <= '0;
      limit_out <= '0;
      watch_key <= '0;
      watch_ok <= 1'b0;
      on_key <= '0;
    end else begin
      state <= next_state;
      point <= next_point;
      acc <= next_acc;
      limit_out <= next_limit_out;
      watch_key <= next_watch_key;
      watch_ok <= next_watch_ok;
      on_key <= next_on_key;
    end
  end

  assign sweep_busy = (state != ST_IDLE);
endmodule // limit_switch_output_compare

// File: verilog/limit_switch_pkg.sv
// constants, codes and helpers shared by the limit switch output unit
package limit_switch_pkg;
  localparam int POINTS = 32;
  localparam int OUT_BITS = 32;
  localparam int PT_W = 5;
  localparam int TGT_W = 5;
  localparam int AXIS_W = 5;
  localparam int QTY_W = 4;
  localparam int IDX_W = 13;
  localparam int TYPE_W = 2;
  localparam int SPACE_W = 2;
  localparam int DATA_W = 64;
  localparam int AXIS_DATA_W = 32;

  localparam int CLK_PERIOD_NS = 20;
  localparam int OP_CYCLE_US = 888;
  localparam int OP_CYCLE_CLOCKS = (OP_CYCLE_US * 1000) / CLK_PERIOD_NS;

  localparam logic [TYPE_W-1:0] TYPE_INT16 = 2'h0;
  localparam logic [TYPE_W-1:0] TYPE_INT32 = 2'h1;
  localparam logic [TYPE_W-1:0] TYPE_FLOAT64 = 2'h2;

  localparam logic [QTY_W-1:0] QTY_FEED = 4'h0;
  localparam logic [QTY_W-1:0] QTY_REAL = 4'h1;
  localparam logic [QTY_W-1:0] QTY_DEVIATION = 4'h2;
  localparam logic [QTY_W-1:0] QTY_MOTOR_CURRENT = 4'h3;
  localparam logic [QTY_W-1:0] QTY_MOTOR_SPEED = 4'h4;
  localparam logic [QTY_W-1:0] QTY_CAM_SHAFT = 4'h5;
  localparam logic [QTY_W-1:0] QTY_FEED_VIRTUAL = 4'h6;
  localparam logic [QTY_W-1:0] QTY_DIFF_VIRTUAL = 4'h7;
  localparam logic [QTY_W-1:0] QTY_DIFF_ENCODER = 4'h8;
  localparam logic [QTY_W-1:0] QTY_ENCODER = 4'h9;

  localparam logic [AXIS_W:0] AXES_LARGE = 6'h20;
  localparam logic [AXIS_W:0] AXES_SMALL = 6'h08;
  localparam logic [AXIS_W:0] VIRT_AXES_LARGE = 6'h0C;

  localparam logic [PT_W-1:0] LAST_POINT = 5'h1F;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WATCH = 4'h2,
    ST_ON = 4'h4,
    ST_OFF = 4'h8
  } seq_state_t;

  // maps a raw value of the given type onto an unsigned key of the same order
  function automatic logic [DATA_W-1:0] order_key(input logic [DATA_W-1:0] raw, input logic [TYPE_W-1:0] typ);
    logic [DATA_W-1:0] ext;
    ext = raw;
    if (typ == TYPE_INT16) begin
      ext = {{48{raw[15]}}, raw[15:0]};
    end else if (typ == TYPE_INT32) begin
      ext = {{32{raw[31]}}, raw[31:0]};
    end
    if (typ == TYPE_FLOAT64 && raw[63]) begin
      return ~raw;
    end
    return {~ext[63], ext[62:0]};
  endfunction
endpackage

// File: verilog/limit_window.sv
// on/off window comparison for one point
`timescale 1ns/1ps
module limit_window (
  input wire logic [limit_switch_pkg::DATA_W-1:0] watch_key,
  input wire logic [limit_switch_pkg::DATA_W-1:0] on_key,
  input wire logic [limit_switch_pkg::DATA_W-1:0] off_key,
  output logic in_window
);
  import limit_switch_pkg::*;

  always_comb begin
    if (on_key < off_key) begin
      in_window = (watch_key >= on_key) && (watch_key < off_key); // [R11]
    end else if (on_key > off_key) begin
      in_window = (watch_key >= on_key) || (watch_key < off_key); // [R11]
    end else begin
      in_window = 1'b0; // [R11]
    end
  end
endmodule // limit_window
